// ===== design/dim_map.svh
// Register offsets, field positions, reset values and code limits of the input function mapper
`ifndef DIM_MAP_SVH
`define DIM_MAP_SVH
// Register byte offsets
`define DIM_SEL_LO_OFF 12'h000
`define DIM_SEL_HI_OFF 12'h004
`define DIM_LIM_OFF 12'h008
`define DIM_RAMP_OFF 12'h00c
`define DIM_FLD_OFF 12'h010
`define DIM_MODE_OFF 12'h014
`define DIM_AN_OFF 12'h018
`define DIM_STAT_OFF 12'h01c
`define DIM_CUR_OFF 12'h020
`define DIM_RAMPO_OFF 12'h024
`define DIM_FLDO_OFF 12'h028
// Selector fields: five bits per input, input n at bit 5*(n mod 3)
`define DIM_SEL_W 5
// Selector reset codes for inputs 1..6
`define DIM_SEL_RST_LO 32'h0000_3580
`define DIM_SEL_RST_HI 32'h0000_1481
// Highest accepted function code for each release
`define DIM_CODE_MAX_NEW 5'h14
`define DIM_CODE_MAX_OLD 5'h12
// Full scale of a percentage level
`define DIM_FULL 8'h64
// Analog role codes
`define DIM_ROLE_NONE 2'h0
`define DIM_ROLE_CLIM 2'h1
`define DIM_ROLE_DEC 2'h2
// Control mode slave value
`define DIM_MODE_SLAVE 2'h3
// Reset values of the settings
`define DIM_LIM_RST 32'h0064_6464
`define DIM_RAMP_RST 32'h0000_0064
`define DIM_FLD_RST 32'h0000_0064
`define DIM_MODE_RST 32'h0000_0032
`endif

// ===== design/dim_pkg.sv
// Types shared by the input function mapper
`default_nettype none
package dim_pkg;
  typedef logic [4:0] dim_code_t;
  typedef logic [7:0] dim_pct_t;
  typedef enum logic [1:0] {
    dim_idle_e = 2'b01,
    dim_acc_e = 2'b10
  } dim_bus_e;
endpackage
`default_nettype wire

// ===== design/dim_mapper.sv
// Digital input function mapper and analog limit scaler behind an APB slave
// What this block does
// [R1] A full-scale external current limit with full-scale settings yields rated current capped by the hardware ceiling.
// [R2] A lower external current limit level scales the applied limit in proportion.
// [R3] With several current limit inputs the smallest resulting limit is applied.
// [R4] A full-scale decrease input leaves ramp times and field rated current unchanged.
// [R5] A lower decrease level scales ramp times and field current and lowers rounding by the same percentage.
// [R6] Decrease signals of either polarity act by their magnitude.
// [R7] With several decrease inputs the smallest value is used.
// [R8] Selectors accept codes 0 to 20 in the newer release and 0 to 18 in the older one.
// [R9] Six digital inputs each have their own function selector.
// [R10] A closed code-0 input clears the stored alarm like the two front keys together.
// [R11] Codes 1, 2 and 3 form a binary preset reference selector.
// [R12] A closed code-4 input lowers both bridge current limits by the reduction percentage.
// [R13] A closed code-5 input inverts the speed reference and auxiliary speed references.
// [R14] A closed code-6 input disables the speed loop and builds a current reference.
// [R15] Control mode value 3 gives the same slave behaviour as the code-6 input.
// [R16] In slave operation the current reference bypasses ramp and rounding.
// [R17] A closed input is a synchronised stable level that stays active while closed.
`include "dim_map.svh"
`default_nettype none
module dim_mapper #(
  parameter bit NEW_RELEASE = 1'b1
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Terminal board contacts and analog levels (signed percent)
  input wire logic [5:0] multifunction_digital_input,
  input wire logic [7:0] internal_analog_level_0,
  input wire logic [7:0] internal_analog_level_1,
  input wire logic [7:0] internal_analog_level_2,
  // Drive function outputs
  output logic alarm_clear,
  output logic [2:0] preset_select,
  output logic reverse_ref,
  output logic slave_mode,
  output logic speed_loop_off,
  output logic ramp_bypass,
  output logic [7:0] bridge_a_limit,
  output logic [7:0] bridge_b_limit,
  output logic [7:0] ramp_scale,
  output logic [7:0] rounding_scale,
  output logic [7:0] field_limit
);
  import dim_pkg::*;

  dim_bus_e state;
  logic [31:0] sel_lo, sel_hi, lim_reg, ramp_reg, fld_reg, mode_reg, an_reg;
  logic [5:0] s1, s2, s3;
  logic [5:0] active;

  // Three-stage synchroniser; a change counts when stages two and three agree
  // [R17] stable closed level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= 6'h00;
      s2 <= 6'h00;
      s3 <= 6'h00;
      active <= 6'h00;
    end else begin
      s1 <= multifunction_digital_input;
      s2 <= s1;
      s3 <= s2;
      active <= (s2 & s3) | (active & (s2 | s3));
    end
  end

  // [R9] one selector per input
  dim_code_t sel [6];
  logic [5:0] hit0, hit1, hit2, hit3, hit4, hit5, hit6;
  wire dim_code_t code_max = NEW_RELEASE ? `DIM_CODE_MAX_NEW : `DIM_CODE_MAX_OLD;
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_in
      wire [31:0] src = (g < 3) ? sel_lo : sel_hi;
      assign sel[g] = src[(g % 3) * `DIM_SEL_W +: `DIM_SEL_W];
      assign hit0[g] = active[g] && sel[g] == 5'h00;
      assign hit1[g] = active[g] && sel[g] == 5'h01;
      assign hit2[g] = active[g] && sel[g] == 5'h02;
      assign hit3[g] = active[g] && sel[g] == 5'h03;
      assign hit4[g] = active[g] && sel[g] == 5'h04;
      assign hit5[g] = active[g] && sel[g] == 5'h05;
      assign hit6[g] = active[g] && sel[g] == 5'h06;
    end
  endgenerate

  // Analog roles and polarities: an_reg[2i+1:2i] role, an_reg[8+i] positive-only
  wire [7:0] lvl [3];
  assign lvl[0] = internal_analog_level_0;
  assign lvl[1] = internal_analog_level_1;
  assign lvl[2] = internal_analog_level_2;
  dim_pct_t clim_mag [3];
  dim_pct_t dec_mag [3];
  generate
    for (g = 0; g < 3; g++) begin : g_an
      wire neg = lvl[g][7];
      wire [7:0] mag_raw = neg ? 8'(-lvl[g]) : lvl[g];
      wire dim_pct_t mag = (mag_raw > `DIM_FULL) ? `DIM_FULL : mag_raw;
      wire [1:0] role = an_reg[2 * g +: 2];
      // Positive-only polarity zeroes a negative limit signal
      wire dim_pct_t cl = (an_reg[8 + g] && neg) ? 8'h00 : mag;
      assign clim_mag[g] = (role == `DIM_ROLE_CLIM) ? cl : `DIM_FULL;
      // [R6] decrease acts on magnitude
      assign dec_mag[g] = (role == `DIM_ROLE_DEC) ? mag : `DIM_FULL;
    end
  endgenerate

  // [R3] smallest current limit
  wire dim_pct_t clim_min01 = (clim_mag[0] < clim_mag[1]) ? clim_mag[0] : clim_mag[1];
  wire dim_pct_t clim_min = (clim_min01 < clim_mag[2]) ? clim_min01 : clim_mag[2];
  // [R7] smallest decrease value
  wire dim_pct_t dec_min01 = (dec_mag[0] < dec_mag[1]) ? dec_mag[0] : dec_mag[1];
  wire dim_pct_t dec_min = (dec_min01 < dec_mag[2]) ? dec_min01 : dec_mag[2];

  // Percent product, result in percent of rated value
  function automatic dim_pct_t pmul(input dim_pct_t a, input dim_pct_t b);
    logic [15:0] p;
    // Widen before the product so that 100 x 100 does not wrap at 8 bits
    p = 16'(a) * 16'(b);
    pmul = 8'(p / 16'h0064);
  endfunction

  // lim_reg: [7:0] rated current, [15:8] bridge A, [23:16] bridge B, [31:24] ceiling
  wire dim_pct_t rated = lim_reg[7:0];
  wire dim_pct_t ceil_lim = lim_reg[31:24];
  wire dim_pct_t reduce = mode_reg[15:8];
  wire any4 = |hit4;
  // [R12] reduction percentage applies to both bridges
  wire dim_pct_t red_f = any4 ? 8'(`DIM_FULL - reduce) : `DIM_FULL;
  // [R1] [R2] rated current scaled by setting and external level
  wire dim_pct_t base_a = pmul(pmul(pmul(rated, lim_reg[15:8]), clim_min), red_f);
  wire dim_pct_t base_b = pmul(pmul(pmul(rated, lim_reg[23:16]), clim_min), red_f);
  // [R1] hardware ceiling caps the result
  wire dim_pct_t next_lim_a = (base_a > ceil_lim) ? ceil_lim : base_a;
  wire dim_pct_t next_lim_b = (base_b > ceil_lim) ? ceil_lim : base_b;
  // [R4] [R5] proportional scale of ramps, rounding and field
  wire dim_pct_t next_ramp = pmul(ramp_reg[7:0], dec_min);
  wire dim_pct_t next_round = pmul(ramp_reg[15:8], dec_min);
  wire dim_pct_t next_fld = pmul(fld_reg[7:0], dec_min);
  // [R15] control mode 3 equals the slave input
  wire next_slave = (|hit6) || (mode_reg[1:0] == `DIM_MODE_SLAVE);

  // Registered drive outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_clear <= 1'b0;
      preset_select <= 3'h0;
      reverse_ref <= 1'b0;
      slave_mode <= 1'b0;
      speed_loop_off <= 1'b0;
      ramp_bypass <= 1'b0;
      bridge_a_limit <= 8'h00;
      bridge_b_limit <= 8'h00;
      ramp_scale <= 8'h00;
      rounding_scale <= 8'h00;
      field_limit <= 8'h00;
    end else begin
      // [R10] alarm clear while closed
      alarm_clear <= |hit0;
      // [R11] binary preset selector
      preset_select <= {|hit3, |hit2, |hit1};
      // [R13] reference reversal
      reverse_ref <= |hit5;
      // [R14] slave disables speed loop
      slave_mode <= next_slave;
      speed_loop_off <= next_slave;
      // [R16] no ramp or rounding in slave
      ramp_bypass <= next_slave;
      bridge_a_limit <= next_lim_a;
      bridge_b_limit <= next_lim_b;
      ramp_scale <= next_slave ? 8'h00 : next_ramp;
      rounding_scale <= next_slave ? 8'h00 : next_round;
      field_limit <= next_fld;
    end
  end

  // APB decode; no wait states, out-of-range selector codes refused
  wire wr = psel && penable && pwrite && state == dim_acc_e;
  wire rd_hit = paddr[11:2] <= 10'h00a && paddr[1:0] == 2'h0;
  // [R8] selector code range check
  wire sel_bad = (paddr == `DIM_SEL_LO_OFF || paddr == `DIM_SEL_HI_OFF) &&
                 (pwdata[4:0] > code_max || pwdata[9:5] > code_max ||
                  pwdata[14:10] > code_max);
  wire err = !rd_hit || (pwrite && sel_bad);
  logic [31:0] rd_mux;
  always_comb begin
    case (paddr)
      `DIM_SEL_LO_OFF: rd_mux = sel_lo;
      `DIM_SEL_HI_OFF: rd_mux = sel_hi;
      `DIM_LIM_OFF: rd_mux = lim_reg;
      `DIM_RAMP_OFF: rd_mux = ramp_reg;
      `DIM_FLD_OFF: rd_mux = fld_reg;
      `DIM_MODE_OFF: rd_mux = mode_reg;
      `DIM_AN_OFF: rd_mux = an_reg;
      `DIM_STAT_OFF: rd_mux = {20'h0, ramp_bypass, reverse_ref, slave_mode,
                               preset_select, active};
      `DIM_CUR_OFF: rd_mux = {16'h0, bridge_b_limit, bridge_a_limit};
      `DIM_RAMPO_OFF: rd_mux = {16'h0, rounding_scale, ramp_scale};
      `DIM_FLDO_OFF: rd_mux = {24'h0, field_limit};
      default: rd_mux = 32'h0;
    endcase
  end

  // Bus state and answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= dim_idle_e;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      case (state)
        dim_idle_e: begin
          pready <= 1'b0;
          pslverr <= 1'b0;
          if (psel && !penable) begin
            state <= dim_acc_e;
            pready <= 1'b1;
            pslverr <= err;
            prdata <= (pwrite || err) ? 32'h0 : rd_mux;
          end
        end
        dim_acc_e: begin
          state <= dim_idle_e;
          pready <= 1'b0;
          pslverr <= 1'b0;
        end
        default: state <= dim_idle_e;
      endcase
    end
  end

  // Register writes take effect at the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_lo <= `DIM_SEL_RST_LO;
      sel_hi <= `DIM_SEL_RST_HI;
      lim_reg <= `DIM_LIM_RST;
      ramp_reg <= `DIM_RAMP_RST;
      fld_reg <= `DIM_FLD_RST;
      mode_reg <= `DIM_MODE_RST;
      an_reg <= 32'h0;
    end else if (wr && !pslverr) begin
      case (paddr)
        `DIM_SEL_LO_OFF: sel_lo <= {17'h0, pwdata[14:0]};
        `DIM_SEL_HI_OFF: sel_hi <= {17'h0, pwdata[14:0]};
        `DIM_LIM_OFF: lim_reg <= pwdata;
        `DIM_RAMP_OFF: ramp_reg <= {16'h0, pwdata[15:0]};
        `DIM_FLD_OFF: fld_reg <= {24'h0, pwdata[7:0]};
        `DIM_MODE_OFF: mode_reg <= {16'h0, pwdata[15:8], 6'h0, pwdata[1:0]};
        `DIM_AN_OFF: an_reg <= {21'h0, pwdata[10:0]};
        default: ;
      endcase
    end
  end
endmodule // dim_mapper
`default_nettype wire

// ===== verification/dim_mapper_sva.sv
// Port-level checks for the input function mapper
`default_nettype none
module dim_mapper_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Drive side
  input wire logic [5:0] multifunction_digital_input,
  input wire logic alarm_clear,
  input wire logic slave_mode,
  input wire logic speed_loop_off,
  input wire logic ramp_bypass,
  input wire logic [7:0] bridge_a_limit,
  input wire logic [7:0] bridge_b_limit,
  input wire logic [7:0] ramp_scale,
  input wire logic [7:0] rounding_scale
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_READY_AFTER_SETUP: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_ERR_READ_ZERO: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  AST_SLAVE_TRIO: assert property (slave_mode |-> speed_loop_off && ramp_bypass)
    else $error("slave outputs disagree");
  AST_BYPASS_ZERO: assert property (ramp_bypass [*3] |-> ramp_scale == 8'h00 && rounding_scale == 8'h00)
    else $error("ramp active in slave");
  AST_LIMIT_CAP: assert property (bridge_a_limit <= 8'h64 && bridge_b_limit <= 8'h64)
    else $error("limit above full scale");
  AST_CONTACT_LAG: assert property ($rose(alarm_clear) |-> $past(multifunction_digital_input, 4) != 6'h00)
    else $error("alarm clear without contact");
endmodule // dim_mapper_chk
bind dim_mapper dim_mapper_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .multifunction_digital_input(multifunction_digital_input), .alarm_clear(alarm_clear),
  .slave_mode(slave_mode), .speed_loop_off(speed_loop_off), .ramp_bypass(ramp_bypass),
  .bridge_a_limit(bridge_a_limit), .bridge_b_limit(bridge_b_limit),
  .ramp_scale(ramp_scale), .rounding_scale(rounding_scale));
`default_nettype wire

// ===== verification/dim_terminal.sv
// Terminal board stand-in: contacts and analog percent levels
`default_nettype none
module dim_terminal (
  // Clock
  input wire logic pclk,
  // Requested states
  input wire logic [5:0] want_di,
  input wire logic [23:0] want_an,
  // Terminal lines
  output logic [5:0] multifunction_digital_input = 6'h00,
  output logic [7:0] internal_analog_level_0 = 8'h64,
  output logic [7:0] internal_analog_level_1 = 8'h64,
  output logic [7:0] internal_analog_level_2 = 8'h64
);
  timeunit 1ns;
  timeprecision 1ns;
  // Lines move one cycle late, so the design never sees the bench's own edge
  always @(posedge pclk) begin
    multifunction_digital_input <= want_di;
    {internal_analog_level_2, internal_analog_level_1, internal_analog_level_0} <= want_an;
  end
endmodule // dim_terminal
`default_nettype wire

// ===== verification/dim_mapper_tb.sv
// Self-checking bench for the input function mapper
`include "dim_map.svh"
`default_nettype none
module dim_mapper_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e, ac, rv, sm, slo, rb;
  logic rdy, perr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, q, prd;
  logic [5:0] want_di = 6'h00, di;
  logic [23:0] want_an = 24'h646464;
  logic [7:0] an0, an1, an2, bal, bbl, rs, rds, fl;
  logic [2:0] ps;
  int bad_count = 0, num_checks = 0;
  // 20 MHz clock
  always #25 pclk = ~pclk;
  dim_terminal term (.pclk(pclk), .want_di(want_di), .want_an(want_an),
    .multifunction_digital_input(di), .internal_analog_level_0(an0),
    .internal_analog_level_1(an1), .internal_analog_level_2(an2));
  dim_mapper uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prd), .pready(rdy), .pslverr(perr),
    .multifunction_digital_input(di), .internal_analog_level_0(an0),
    .internal_analog_level_1(an1), .internal_analog_level_2(an2), .alarm_clear(ac),
    .preset_select(ps), .reverse_ref(rv), .slave_mode(sm), .speed_loop_off(slo),
    .ramp_bypass(rb), .bridge_a_limit(bal), .bridge_b_limit(bbl), .ramp_scale(rs),
    .rounding_scale(rds), .field_limit(fl));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      bad_count++;
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // One APB transfer; response is captured at the edge where pready is seen
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (rdy !== 1'b1 && n < 20);
    if (rdy !== 1'b1) begin
      bad_count++;
      tally_and_finish;
    end
    // Answer taken at the edge where pready is seen high
    e = perr;
    q = prd;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge so the next setup never reassigns psel in this time step
    @(posedge pclk);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  // Terminal register, sync chain and output register need six edges; eight leave margin
  task put(input logic [5:0] v, input logic [23:0] an);
    want_di <= v;
    want_an <= an;
    repeat (8) @(posedge pclk);
  endtask
  task t_regs;
    // Reset codes 0, 12, 13 and 1, 4, 5 packed five bits apart
    rd(`DIM_SEL_LO_OFF); chk(q, (32'h0000_000d << 10) | (32'h0000_000c << 5));
    rd(`DIM_SEL_HI_OFF); chk(q, (32'h0000_0005 << 10) | (32'h0000_0004 << 5) | 32'h1);
    wr(`DIM_SEL_LO_OFF, 32'h15); chk(e, 1'b1);
    rd(`DIM_SEL_LO_OFF); chk(q, (32'h0000_000d << 10) | (32'h0000_000c << 5));
    wr(`DIM_SEL_HI_OFF, 32'h5294); chk(e, 1'b0);
    rd(12'h02c); chk(e, 1'b1);
    wr(`DIM_SEL_HI_OFF, `DIM_SEL_RST_HI);
  endtask
  task t_inputs;
    int i;
    put(6'h01, 24'h646464); chk(ac, 1'b1);
    put(6'h00, 24'h646464); chk(ac, 1'b0);
    wr(`DIM_SEL_LO_OFF, 32'h0c41);
    for (i = 0; i < 8; i++) begin
      put(i[5:0], 24'h646464); chk(ps, i[2:0]);
    end
    put(6'h20, 24'h646464); chk(rv, 1'b1);
  endtask
  task t_limit;
    wr(`DIM_LIM_OFF, 32'h6464_6432);
    wr(`DIM_AN_OFF, 32'h05);
    put(6'h00, 24'h003264); chk(bal, 8'h19);
    chk(bbl, 8'h19);
    put(6'h00, 24'h006464); chk(bal, 8'h32);
    wr(`DIM_LIM_OFF, 32'h2864_6432);
    put(6'h00, 24'h006464); chk(bal, 8'h28);
    wr(`DIM_LIM_OFF, 32'h6464_6432);
    wr(`DIM_MODE_OFF, 32'h3200);
    put(6'h10, 24'h006464); chk({bal, bbl}, 16'h1919);
  endtask
  task t_dec;
    wr(`DIM_RAMP_OFF, 32'h5064);
    wr(`DIM_AN_OFF, 32'h22);
    put(6'h00, 24'hce0050); chk(rs, 8'h32);
    chk(rds, 8'h28);
    chk(fl, 8'h32);
    put(6'h00, 24'h640064); chk({rs, rds, fl}, 24'h645064);
  endtask
  task t_slave;
    wr(`DIM_MODE_OFF, 32'h3);
    put(6'h00, 24'h646464); chk({sm, slo, rb}, 3'b111);
    chk(rs, 8'h00);
    wr(`DIM_MODE_OFF, 32'h0);
    wr(`DIM_SEL_HI_OFF, 32'h1881);
    put(6'h20, 24'h646464); chk({sm, slo, rb, rds}, 11'h700);
    put(6'h00, 24'h646464); chk(sm, 1'b0);
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_inputs;
    t_limit;
    t_dec;
    t_slave;
    tally_and_finish;
  end
endmodule // dim_mapper_tb
`default_nettype wire
